/* File: logic/acc_clk_div.sv */
`default_nettype none
module acc_clk_div (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       src_tick,
  input  wire logic [2:0] div_code,
  output logic            conv_tick
);
  import acc_pkg::*;

  logic [3:0] cnt_reg;
  logic [3:0] last_count;
  logic [2:0] code_sat;

  ////////////////////////////////////////////////////////////////////////////////
  // Divide ratio is 1, 2, 4, 8 or 16 source ticks per converter tick
  always_comb begin
    code_sat   = (div_code > DIV_CODE_MAX) ? DIV_CODE_MAX : div_code;
    last_count = 4'((5'h1 << code_sat) - 5'h1);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 4'h0;
    end else if (src_tick) begin
      // A ratio change mid count wraps early rather than waiting out 16
      cnt_reg <= (cnt_reg >= last_count) ? 4'h0 : cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= src_tick && (cnt_reg >= last_count);
    end
  end

endmodule
`default_nettype wire

/* File: logic/acc_pkg.sv */
`default_nettype none
package acc_pkg;

  // Result and channel geometry
  localparam int          RESULT_W        = 10;
  localparam int          CHAN_SEL_W      = 5;
  localparam int          PORT_PINS       = 8;
  localparam logic [4:0]  CHAN_POWER_OFF  = 5'h1f;

  // Conversion timing in converter clock ticks
  localparam int          CONV_TICKS      = 16;
  localparam int          SAMPLE_TICKS    = 4;
  localparam logic [4:0]  CNT_LAST        = 5'(CONV_TICKS - 1);
  localparam logic [4:0]  CNT_SAMPLE_LAST = 5'(SAMPLE_TICKS - 1);
  localparam logic [9:0]  SAR_FIRST_TRIAL = 10'h200;
  localparam logic [9:0]  RESULT_FULL     = 10'h3ff;

  // Justification codes, {justify_sel_hi, justify_sel_lo}
  localparam logic [1:0]  JUST_TRUNC8     = 2'h0;
  localparam logic [1:0]  JUST_RIGHT      = 2'h1;
  localparam logic [1:0]  JUST_LEFT       = 2'h2;
  localparam logic [1:0]  JUST_LEFT_SIGN  = 2'h3;

  // Reset values of the status/control and clock configuration fields
  localparam logic        RST_CONTINUOUS  = 1'b0;
  localparam logic        RST_IRQ_ENABLE  = 1'b0;
  localparam logic [4:0]  RST_CHANNEL     = 5'h1f;
  localparam logic [1:0]  RST_JUSTIFY     = JUST_RIGHT;
  localparam logic [2:0]  RST_CLK_DIVIDER = 3'h0;
  localparam logic        RST_CLK_SOURCE  = 1'b0;

  // Prescaler: codes at or above this value divide by sixteen
  localparam logic [2:0]  DIV_CODE_MAX    = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_SAR    = 4'b0100,
    ST_SETTLE = 4'b1000
  } acc_state_t;

endpackage
`default_nettype wire

/* File: logic/acc_top.sv */
`default_nettype none
module acc_top (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       scr_wr,
  input  wire logic                       scr_continuous_enable,
  input  wire logic                       scr_conv_irq_enable,
  input  wire logic [acc_pkg::CHAN_SEL_W-1:0] scr_channel_select,
  input  wire logic                       justify_sel_hi,
  input  wire logic                       justify_sel_lo,
  input  wire logic [2:0]                 conv_clock_divider,
  input  wire logic                       conv_clock_source_sel,
  input  wire logic                       osc_tick,
  input  wire logic                       result_high_rd,
  input  wire logic                       result_low_rd,
  input  wire logic                       stop_mode,
  input  wire logic                       comp_above,
  output logic                            continuous_enable,
  output logic                            conv_irq_enable,
  output logic [acc_pkg::CHAN_SEL_W-1:0]  channel_select,
  output logic                            conv_complete_flag,
  output logic                            conv_irq,
  output logic [7:0]                      result_high,
  output logic [7:0]                      result_low,
  output logic                            conv_busy,
  output logic                            sample_hold,
  output logic                            analog_enable,
  output logic [acc_pkg::RESULT_W-1:0]    dac_code,
  output logic [acc_pkg::PORT_PINS-1:0]   analog_port_pins
);
  import acc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  acc_state_t              state_reg;
  logic [4:0]              tick_cnt_reg;
  logic [RESULT_W-1:0]     trial_mask_reg;
  logic                    interlock_reg;
  logic                    stop_prev_reg;
  logic                    resume_pending_reg;
  logic                    conv_tick;
  logic                    lead_tick_reg;
  logic                    seq_tick;
  logic                    src_tick;
  logic [4:0]              chan_next;
  logic                    cont_next;
  logic                    power_off_next;
  logic                    stop_exit;
  logic                    conv_done;
  logic                    start_conv;
  logic                    data_read;
  logic                    store_ok;
  logic [1:0]              justify;
  logic [RESULT_W-1:0]     sar_value;
  logic [7:0]              fmt_high;
  logic [7:0]              fmt_low;

  ////////////////////////////////////////////////////////////////////////////////
  // Converter clock prescaler

  // Bus clock source ticks every cycle; the oscillator source arrives as an enable
  assign src_tick = conv_clock_source_sel ? 1'b1 : osc_tick;

  acc_clk_div u_clk_div (
    .clk       (clk),
    .rst_b     (rst_b),
    .src_tick  (src_tick),
    .div_code  (conv_clock_divider),
    .conv_tick (conv_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Control decode

  always_comb begin
    chan_next      = scr_wr ? scr_channel_select : channel_select;
    cont_next      = scr_wr ? scr_continuous_enable : continuous_enable;
    power_off_next = (chan_next == CHAN_POWER_OFF);
    stop_exit      = stop_prev_reg && !stop_mode;
    conv_done      = seq_tick && (state_reg == ST_SETTLE) && (tick_cnt_reg == CNT_LAST);
    data_read      = result_high_rd || result_low_rd;
    justify        = {justify_sel_hi, justify_sel_lo};
  end

  // Start sources: a control write, a stop exit with work pending, or a
  // back-to-back restart in continuous mode; stop and power-off veto all
  always_comb begin
    start_conv = 1'b0;
    if (!stop_mode && !power_off_next) begin
      if (scr_wr) begin
        start_conv = 1'b1;
      end else if (stop_exit && resume_pending_reg) begin
        start_conv = 1'b1;
      end else if (conv_done && cont_next) begin
        start_conv = 1'b1;
      end
    end
  end

  // The divider free-runs, so the first tick after a start is a partial
  // period; skipping it keeps every conversion at 16 to 17 full ticks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lead_tick_reg <= 1'b0;
    end else if (start_conv) begin
      lead_tick_reg <= 1'b1;
    end else if (conv_tick) begin
      lead_tick_reg <= 1'b0;
    end
  end

  assign seq_tick = conv_tick && !lead_tick_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Status/control fields

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      continuous_enable <= RST_CONTINUOUS;
      conv_irq_enable   <= RST_IRQ_ENABLE;
      channel_select    <= RST_CHANNEL;
    end else if (scr_wr) begin
      continuous_enable <= scr_continuous_enable;
      conv_irq_enable   <= scr_conv_irq_enable;
      channel_select    <= scr_channel_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  // Wait mode is not an input: the sequencer never gates on it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ST_IDLE;
      tick_cnt_reg <= 5'h0;
    end else if (stop_mode || power_off_next) begin
      state_reg    <= ST_IDLE;
      tick_cnt_reg <= 5'h0;
    end else if (start_conv) begin
      // Count starts over; the partial first tick is skipped, giving 16-17
      state_reg    <= ST_SAMPLE;
      tick_cnt_reg <= 5'h0;
    end else if (seq_tick) begin
      unique case (state_reg)
        ST_IDLE: begin
          tick_cnt_reg <= 5'h0;
        end
        ST_SAMPLE: begin
          tick_cnt_reg <= tick_cnt_reg + 5'h1;
          if (tick_cnt_reg == CNT_SAMPLE_LAST) begin
            state_reg <= ST_SAR;
          end
        end
        ST_SAR: begin
          tick_cnt_reg <= tick_cnt_reg + 5'h1;
          if (trial_mask_reg[0]) begin
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          tick_cnt_reg <= tick_cnt_reg + 5'h1;
          if (tick_cnt_reg == CNT_LAST) begin
            // Single mode parks here until the next control write
            state_reg    <= ST_IDLE;
            tick_cnt_reg <= 5'h0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Successive approximation

  // Each tick keeps or drops the trial bit by the comparator, then tries the
  // next; a comparator held high ends on all ones, held low on zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dac_code       <= 10'h000;
      trial_mask_reg <= 10'h000;
    end else if (start_conv) begin
      dac_code       <= 10'h000;
      trial_mask_reg <= 10'h000;
    end else if (seq_tick) begin
      if (state_reg == ST_SAMPLE && tick_cnt_reg == CNT_SAMPLE_LAST) begin
        dac_code       <= SAR_FIRST_TRIAL;
        trial_mask_reg <= SAR_FIRST_TRIAL;
      end else if (state_reg == ST_SAR) begin
        dac_code       <= (comp_above ? dac_code : (dac_code & ~trial_mask_reg))
                          | (trial_mask_reg >> 1);
        trial_mask_reg <= trial_mask_reg >> 1;
      end
    end
  end

  assign sar_value = dac_code;

  ////////////////////////////////////////////////////////////////////////////////
  // Stop mode tracking

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_prev_reg      <= 1'b0;
      resume_pending_reg <= 1'b0;
    end else begin
      stop_prev_reg <= stop_mode;
      if (stop_mode) begin
        // Resume whatever was under way or asked for when stop came in
        if (state_reg != ST_IDLE || scr_wr || continuous_enable) begin
          resume_pending_reg <= 1'b1;
        end
      end else if (stop_exit) begin
        resume_pending_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result formatting

  always_comb begin
    fmt_high = 8'h00;
    fmt_low  = 8'h00;
    unique case (justify)
      JUST_TRUNC8: begin
        fmt_low = sar_value[9:2];
      end
      JUST_RIGHT: begin
        fmt_high = {6'h00, sar_value[9:8]};
        fmt_low  = sar_value[7:0];
      end
      JUST_LEFT: begin
        fmt_high = sar_value[9:2];
        fmt_low  = {sar_value[1:0], 6'h00};
      end
      JUST_LEFT_SIGN: begin
        fmt_high = {~sar_value[9], sar_value[8:2]};
        fmt_low  = {sar_value[1:0], 6'h00};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data registers and read interlock

  // A low read in the same cycle as a high read releases the lock at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      interlock_reg <= 1'b0;
    end else if (justify == JUST_TRUNC8) begin
      interlock_reg <= 1'b0;
    end else if (result_low_rd) begin
      interlock_reg <= 1'b0;
    end else if (result_high_rd) begin
      interlock_reg <= 1'b1;
    end
  end

  assign store_ok = (justify == JUST_TRUNC8) || !interlock_reg;

  // Unread data is overwritten freely; only the interlock holds it back
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_high <= 8'h00;
      result_low  <= 8'h00;
    end else if (conv_done && store_ok) begin
      result_high <= fmt_high;
      result_low  <= fmt_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Completion flag and interrupt request

  // A completion in the cycle of a clearing read wins over the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_complete_flag <= 1'b0;
    end else if (conv_irq_enable) begin
      conv_complete_flag <= 1'b0;
    end else if (conv_done) begin
      conv_complete_flag <= 1'b1;
    end else if (data_read) begin
      conv_complete_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_irq <= 1'b0;
    end else if (conv_done && conv_irq_enable) begin
      conv_irq <= 1'b1;
    end else if (data_read || scr_wr || !conv_irq_enable) begin
      conv_irq <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Analog side controls

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_busy   <= 1'b0;
      sample_hold <= 1'b0;
    end else begin
      conv_busy   <= (state_reg != ST_IDLE) && !stop_mode;
      sample_hold <= (state_reg == ST_SAMPLE) && !stop_mode;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_enable <= 1'b0;
    end else begin
      analog_enable <= !power_off_next && !stop_mode;
    end
  end

  // Only the selected port pin is forced to an analog input
  for (genvar i = 0; i < PORT_PINS; i++) begin : g_pin
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        analog_port_pins[i] <= 1'b0;
      end else begin
        analog_port_pins[i] <= (channel_select == 5'(i));
      end
    end
  end

endmodule
`default_nettype wire

/* File: verif/acc_adc_model.sv */
`default_nettype none
module acc_adc_model (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            analog_enable,
  input  wire logic [4:0]      channel_select,
  input  wire logic [9:0]      dac_code,
  input  wire logic [7:0][9:0] chan_level,
  output logic                 comp_above
);
  logic [9:0] vin;
  logic       noise_reg;

  always_comb begin
    if (channel_select == 5'h1d) begin
      vin = 10'h3ff;
    end else if (channel_select == 5'h1e) begin
      vin = 10'h000;
    end else begin
      vin = chan_level[channel_select[2:0]];
    end
  end

  // A powered-down comparator gives no decision, so it must not look like a stable one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      noise_reg <= 1'b0;
    end else begin
      noise_reg <= ~noise_reg;
    end
  end

  assign comp_above = analog_enable ? (vin >= dac_code) : noise_reg;
endmodule
`default_nettype wire

/* File: verif/acc_top_monitor.sv */
`default_nettype none
module acc_top_monitor (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       scr_wr,
  input wire logic       scr_continuous_enable,
  input wire logic       scr_conv_irq_enable,
  input wire logic [4:0] scr_channel_select,
  input wire logic       justify_sel_hi,
  input wire logic       justify_sel_lo,
  input wire logic       result_high_rd,
  input wire logic       result_low_rd,
  input wire logic       stop_mode,
  input wire logic       continuous_enable,
  input wire logic       conv_irq_enable,
  input wire logic [4:0] channel_select,
  input wire logic       conv_complete_flag,
  input wire logic       conv_irq,
  input wire logic [7:0] result_high,
  input wire logic [7:0] result_low,
  input wire logic       conv_busy,
  input wire logic       sample_hold,
  input wire logic       analog_enable,
  input wire logic [7:0] analog_port_pins
);
  import acc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  a_flag_off_irq: assert property (conv_irq_enable && $past(conv_irq_enable) |-> !conv_complete_flag)
    else $error("complete flag set while interrupt enabled");
  a_irq_needs_en: assert property ($rose(conv_irq) |-> conv_irq_enable)
    else $error("interrupt raised while disabled");
  a_wr_readback: assert property (scr_wr |=> continuous_enable == $past(scr_continuous_enable)
    && conv_irq_enable == $past(scr_conv_irq_enable) && channel_select == $past(scr_channel_select))
    else $error("control fields not stored on write");
  a_wr_clr_irq: assert property (scr_wr && !conv_busy |=> !conv_irq)
    else $error("interrupt survived a control write");
  a_rd_clears: assert property ((result_high_rd || result_low_rd) && !conv_busy
    |=> !conv_complete_flag && !conv_irq)
    else $error("data read left flag or interrupt set");
  a_start_busy: assert property (scr_wr && scr_channel_select != CHAN_POWER_OFF && !stop_mode
    |-> ##2 conv_busy && sample_hold)
    else $error("write did not start a conversion");
  a_stop_idle: assert property (stop_mode [*3] |-> !conv_busy && !analog_enable)
    else $error("converter active in stop mode");
  a_power_off: assert property (channel_select == CHAN_POWER_OFF
    && $past(channel_select) == CHAN_POWER_OFF |-> !analog_enable && !conv_busy)
    else $error("converter active while powered off");
  a_pins_map: assert property ($stable(channel_select) |-> analog_port_pins ==
    (channel_select < 5'h08 ? 8'h01 << channel_select[2:0] : 8'h00))
    else $error("wrong port pin taken for analog");
  a_trunc_high: assert property ($changed(result_low)
    && $past({justify_sel_hi, justify_sel_lo}) == JUST_TRUNC8 |-> result_high == 8'h00)
    else $error("high result not zero in truncation");
  a_left_low: assert property ($changed(result_low)
    && $past({justify_sel_hi, justify_sel_lo}) == JUST_LEFT |-> result_low[5:0] == 6'h00)
    else $error("low result spare bits set in left format");
  a_flag_rise: assert property ($rose(conv_complete_flag) |-> !conv_irq_enable && $past(conv_busy))
    else $error("flag set outside a conversion end");
endmodule

bind acc_top acc_top_monitor u_acc_top_monitor (
  .clk, .rst_b, .scr_wr, .scr_continuous_enable, .scr_conv_irq_enable, .scr_channel_select,
  .justify_sel_hi, .justify_sel_lo, .result_high_rd, .result_low_rd, .stop_mode,
  .continuous_enable, .conv_irq_enable, .channel_select, .conv_complete_flag, .conv_irq,
  .result_high, .result_low, .conv_busy, .sample_hold, .analog_enable, .analog_port_pins);
`default_nettype wire

/* File: verif/tb_acc_top.sv */
`default_nettype none
module tb_acc_top;
  timeunit 1ns;
  timeprecision 100ps;
  import acc_pkg::*;

  logic            clk, rst_b, scr_wr, scr_continuous_enable, scr_conv_irq_enable;
  logic            justify_sel_hi, justify_sel_lo, conv_clock_source_sel, osc_tick;
  logic            result_high_rd, result_low_rd, stop_mode, comp_above;
  logic            continuous_enable, conv_irq_enable, conv_complete_flag, conv_irq;
  logic            conv_busy, sample_hold, analog_enable;
  logic [2:0]      conv_clock_divider;
  logic [4:0]      scr_channel_select, channel_select;
  logic [7:0]      result_high, result_low, analog_port_pins;
  logic [9:0]      dac_code;
  logic [7:0][9:0] lvl;
  int              n_mismatch, num_checks;

  acc_top u_acc_top (
    .clk, .rst_b, .scr_wr, .scr_continuous_enable, .scr_conv_irq_enable, .scr_channel_select,
    .justify_sel_hi, .justify_sel_lo, .conv_clock_divider, .conv_clock_source_sel, .osc_tick,
    .result_high_rd, .result_low_rd, .stop_mode, .comp_above, .continuous_enable,
    .conv_irq_enable, .channel_select, .conv_complete_flag, .conv_irq, .result_high,
    .result_low, .conv_busy, .sample_hold, .analog_enable, .dac_code, .analog_port_pins);

  acc_adc_model u_acc_adc_model (
    .clk, .rst_b, .analog_enable, .channel_select, .dac_code, .chan_level(lvl), .comp_above);

  always #2 clk = ~clk;
  // Oscillator enable at half the system rate
  always @(posedge clk) osc_tick <= ~osc_tick;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_val(nm, {15'h0000, e}, {15'h0000, g});
  endtask

  function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] r);
    case (m)
      2'h0: return {8'h00, r[9:2]};
      2'h1: return {6'h00, r};
      2'h2: return {r, 6'h00};
      default: return {~r[9], r[8:0], 6'h00};
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic c, input logic ie, input logic [4:0] ch);
    @(posedge clk);
    #1;
    scr_wr = 1'b1;
    scr_continuous_enable = c;
    scr_conv_irq_enable = ie;
    scr_channel_select = ch;
    @(posedge clk);
    #1;
    scr_wr = 1'b0;
  endtask

  task automatic rd(input logic h, input logic l);
    @(posedge clk);
    #1;
    result_high_rd = h;
    result_low_rd = l;
    @(posedge clk);
    #1;
    result_high_rd = 1'b0;
    result_low_rd = 1'b0;
  endtask

  // Counts edges until flag or interrupt; bounded so a dead converter cannot hang the run
  task automatic wait_done(output int n);
    n = 0;
    while (!(conv_complete_flag === 1'b1 || conv_irq === 1'b1)) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400) begin
        chk_bit("timeout", 1'b1, 1'b0);
        end_sim();
      end
    end
  endtask

  task automatic start(input logic c, input logic ie, input logic [4:0] ch, output int n);
    wr(c, ie, ch);
    wait_done(n);
  endtask

  task automatic conv1(input logic [4:0] ch, input logic [9:0] r, input logic [1:0] m,
                       input int d);
    int n;
    lvl[ch[2:0]] = r;
    {justify_sel_hi, justify_sel_lo} = m;
    start(1'b0, 1'b0, ch, n);
    chk_bit("conv_time", 1'b1, n >= 16 * d - 2 && n <= 17 * d + 2);
    chk_val("result", fmt(m, r), {result_high, result_low});
    rd(1'b1, 1'b1);
    chk_bit("flag_clear", 1'b0, conv_complete_flag);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_formats();
    chk_val("rst_res", 16'h0000, {result_high, result_low});
    chk_val("rst_ctl", 16'h1, {13'h0, conv_complete_flag, conv_busy, &channel_select});
    for (int i = 0; i < 8; i++) begin
      conv1(5'(i), 10'(10'h07b * (i + 1)), 2'(i), 1);
    end
    conv1(5'h1d, 10'h3ff, JUST_LEFT, 1);
    conv1(5'h1e, 10'h000, JUST_RIGHT, 1);
    conv_clock_divider = 3'h1;
    conv_clock_source_sel = 1'b0;
    conv1(5'h2, 10'h19c, JUST_LEFT, 4);
    conv_clock_divider = 3'h5;
    conv_clock_source_sel = 1'b1;
    conv1(5'h2, 10'h19c, JUST_LEFT_SIGN, 16);
    conv_clock_divider = 3'h0;
    $display("test formats done");
  endtask

  task automatic t_modes();
    int n;
    lvl[5] = 10'h2f0;
    {justify_sel_hi, justify_sel_lo} = JUST_RIGHT;
    start(1'b0, 1'b0, 5'h05, n);
    lvl[5] = 10'h10f;
    repeat (60) @(posedge clk);
    #1;
    chk_val("single_idle", 16'h0001, {conv_busy, conv_complete_flag});
    chk_val("single_keep", fmt(JUST_RIGHT, 10'h2f0), {result_high, result_low});
    rd(1'b1, 1'b1);
    start(1'b1, 1'b0, 5'h05, n);
    lvl[5] = 10'h355;
    repeat (40) @(posedge clk);
    #1;
    chk_val("cont_over", fmt(JUST_RIGHT, 10'h355), {result_high, result_low});
    wr(1'b0, 1'b0, 5'h05);
    repeat (40) @(posedge clk);
    rd(1'b1, 1'b1);
    repeat (40) @(posedge clk);
    #1;
    chk_val("cont_stop", 16'h0000, {conv_busy, conv_complete_flag});
    $display("test modes done");
  endtask

  task automatic t_lock();
    int n;
    lvl[1] = 10'h155;
    start(1'b0, 1'b0, 5'h01, n);
    rd(1'b1, 1'b0);
    lvl[1] = 10'h2aa;
    start(1'b0, 1'b0, 5'h01, n);
    chk_val("locked", fmt(JUST_RIGHT, 10'h155), {result_high, result_low});
    rd(1'b0, 1'b1);
    {justify_sel_hi, justify_sel_lo} = JUST_TRUNC8;
    start(1'b0, 1'b0, 5'h01, n);
    chk_val("unlocked", fmt(JUST_TRUNC8, 10'h2aa), {result_high, result_low});
    rd(1'b1, 1'b0);
    lvl[1] = 10'h155;
    start(1'b0, 1'b0, 5'h01, n);
    chk_val("trunc_free", fmt(JUST_TRUNC8, 10'h155), {result_high, result_low});
    rd(1'b1, 1'b1);
    $display("test lock done");
  endtask

  task automatic t_irq_stop();
    int n;
    {justify_sel_hi, justify_sel_lo} = JUST_RIGHT;
    start(1'b0, 1'b1, 5'h04, n);
    chk_val("irq_flag", 16'h0002, {conv_irq, conv_complete_flag});
    rd(1'b0, 1'b1);
    chk_bit("irq_rd", 1'b0, conv_irq);
    start(1'b0, 1'b1, 5'h04, n);
    wr(1'b0, 1'b1, 5'h04);
    chk_bit("irq_wr", 1'b0, conv_irq);
    wait_done(n);
    chk_val("irq_again", 16'h0002, {conv_irq, conv_complete_flag});
    wr(1'b0, 1'b0, 5'h06);
    repeat (8) @(posedge clk);
    lvl[6] = 10'h321;
    start(1'b0, 1'b0, 5'h06, n);
    chk_bit("restart", 1'b1, n >= 14 && n <= 19);
    chk_val("restart_res", fmt(JUST_RIGHT, 10'h321), {result_high, result_low});
    rd(1'b1, 1'b1);
    wr(1'b0, 1'b0, 5'h07);
    repeat (6) @(posedge clk);
    #1 stop_mode = 1'b1;
    repeat (30) @(posedge clk);
    #1;
    chk_val("stopped", 16'h0000, {conv_busy, conv_complete_flag});
    stop_mode = 1'b0;
    wait_done(n);
    chk_val("resumed", fmt(JUST_RIGHT, lvl[7]), {result_high, result_low});
    rd(1'b1, 1'b1);
    wr(1'b0, 1'b0, 5'h07);
    repeat (5) @(posedge clk);
    wr(1'b0, 1'b0, CHAN_POWER_OFF);
    repeat (40) @(posedge clk);
    #1;
    chk_val("off", 16'h0000, {conv_busy, conv_complete_flag, analog_enable});
    $display("test irq and stop done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, rst_b, scr_wr, scr_continuous_enable, scr_conv_irq_enable} = 5'h00;
    {justify_sel_hi, justify_sel_lo, conv_clock_source_sel, osc_tick} = 4'h6;
    {result_high_rd, result_low_rd, stop_mode} = 3'h0;
    conv_clock_divider = 3'h0;
    scr_channel_select = 5'h1f;
    lvl = '0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    t_formats();
    t_modes();
    t_lock();
    t_irq_stop();
    end_sim();
  end
endmodule
`default_nettype wire
